//--- dv/spi_serial_port_bench.sv
`default_nettype none
module spi_serial_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] cfgs [4] = '{8'h09, 8'hb9, 8'h79, 8'hc9};
    logic             clk, rst_n, cyc, we, ste, go, cpha, msb, sck_b, simo_b;
    logic [5:0]       adr;
    logic [7:0]       wd, ptx, q, m;
    logic [3:0]       len;
    int               fails = 0, num_checks = 0, cycles = 0;
    wire logic [31:0] rdat;
    wire logic [7:0]  prx;
    wire logic        ack, sck, sck_o, sck_oe, mo, mo_o, mo_oe, mi, mi_o, mi_oe, pmi;
    assign sck = sck_oe ? sck_o : sck_b;
    assign mo = mo_oe ? mo_o : simo_b;
    assign mi = mi_oe ? mi_o : pmi;
    always #20 clk = ~clk;
    spisp_top dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h0, wd}), .wb_dat_o(rdat),
        .wb_ack_o(ack), .aux_clk_tick(1'h0), .serial_clock_pin_i(sck),
        .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe),
        .slave_in_master_out_pin_i(mo), .slave_in_master_out_pin_o(mo_o),
        .slave_in_master_out_pin_oe(mo_oe), .slave_out_master_in_pin_i(mi),
        .slave_out_master_in_pin_o(mi_o), .slave_out_master_in_pin_oe(mi_oe),
        .slave_enable_pin_i(ste));
    spisp_slave_model model_u (.sclk(sck), .mosi(mo), .miso(pmi), .start(go), .cpha(cpha),
        .msb(msb), .len(len), .tx(ptx), .rx(prx));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d,
                      output logic [7:0] r);
        @(posedge clk);
        {cyc, we, adr, wd} <= {1'h1, w, a, d};
        do @(posedge clk); while (ack !== 1'h1);
        r = rdat[7:0];
        cyc <= 1'h0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] r;
        wb(1'h1, a, d, r);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e, input string n);
        logic [7:0] r;
        wb(1'h0, a, 8'h00, r);
        chk(n, r, e);
    endtask
    task automatic setup(input logic [7:0] c);
        wr(6'h04, 8'h81);
        wr(6'h00, c);
        wr(6'h08, 8'h08);
        wr(6'h0c, 8'h00);
        wr(6'h04, 8'h80);
        {cpha, msb, len} <= {c[7], c[5], c[4] ? 4'h7 : 4'h8};
    endtask
    task automatic arm(input logic [7:0] p);
        @(posedge clk);
        ptx <= p;
        go <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
    endtask
    task automatic wait_bit(input logic [5:0] a, input logic v);
        logic [7:0] f;
        f = {7'h0, !v};
        while (f[0] !== v)
            wb(1'h0, a, 8'h00, f);
    endtask
    task automatic xfer(input logic [7:0] d, input logic [7:0] p);
        arm(p);
        wr(6'h1c, d);
        rd(6'h14, 8'h01, "busy");
        wait_bit(6'h14, 1'h0);
    endtask
    task automatic slv(input logic [7:0] d, output logic [7:0] r);
        for (int e = 0; e < 16; e++)
        begin
            if (e % 2 == 0)
                simo_b <= d[7 - e / 2];
            repeat (4) @(posedge clk);
            if (e % 2 == 0)
                r[7 - e / 2] = mi;
            sck_b <= ~sck_b;
        end
        simo_b <= ~simo_b;
    endtask
    task final_report;
        if (fails == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            final_report;
        end
    end
    initial
    begin
        {clk, rst_n, cyc, we, ste, go, cpha, msb, sck_b, simo_b} = 10'h0;
        {adr, wd, ptx, len} = 26'h8;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        rd(6'h04, 8'h01, "ctl1_reset");
        rd(6'h24, 8'h02, "flags_reset");
        rd(6'h28, 8'h00, "unmapped");
        for (int i = 0; i < 4; i++)
        begin
            setup(cfgs[i]);
            m = cfgs[i][4] ? 8'h7f : 8'hff;
            xfer(8'hc5, 8'hb3);
            chk("link_out", prx, 8'hc5 & m);
            rd(6'h18, 8'hb3 & m, "rx_buffer");
            rd(6'h24, 8'h02, "flags");
            chk("clk_idle", {7'h0, sck}, {7'h0, cfgs[i][6]});
        end
        xfer(8'h11, 8'h22);
        xfer(8'h33, 8'h44);
        rd(6'h14, 8'h20, "overrun");
        wr(6'h20, 8'h03);
        wr(6'h04, 8'h81);
        rd(6'h14, 8'h00, "soft_status");
        rd(6'h20, 8'h00, "soft_enables");
        rd(6'h24, 8'h02, "soft_flags");
        ste <= 1'h1;
        setup(8'h0b);
        wr(6'h1c, 8'h5e);
        rd(6'h14, 8'h40, "mode_fault");
        chk("clk_drive", {7'h0, sck_oe}, 8'h00);
        arm(8'h81);
        ste <= 1'h0;
        wait_bit(6'h24, 1'h1);
        chk("resume_out", prx, 8'h5e);
        ste <= 1'h1;
        setup(8'ha1);
        wr(6'h1c, 8'h96);
        slv(8'h5a, q);
        chk("slave_out", q, 8'h96);
        wait_bit(6'h24, 1'h1);
        rd(6'h18, 8'h5a, "slave_in");
        setup(8'ha5);
        chk("slave_release", {7'h0, mi_oe}, 8'h00);
        ste <= 1'h0;
        wr(6'h1c, 8'h3c);
        slv(8'hc3, q);
        chk("slave4_out", q, 8'h3c);
        wait_bit(6'h24, 1'h1);
        rd(6'h18, 8'hc3, "slave4_in");
        final_report;
    end
endmodule
`default_nettype wire

//--- dv/spisp_slave_model.sv
`default_nettype none
module spisp_slave_model (
    input  wire logic       sclk,
    input  wire logic       mosi,
    output logic            miso,
    input  wire logic       start,
    input  wire logic       cpha,
    input  wire logic       msb,
    input  wire logic [3:0] len,
    input  wire logic [7:0] tx,
    output logic      [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 32;
    function automatic int pos(input int k);
        return msb ? int'(len) - 1 - k : k;
    endfunction
    initial miso = 1'h0;
    always @(posedge start)
    begin
        n = 0;
        rx = 8'h00;
        miso = tx[pos(0)];
    end
    ////////////////////////////////////////////////////////////////////////////
    // edges counted from one; capture on the edge opposite the launch
    always @(sclk)
    begin
        if (n < 2 * int'(len))
        begin
            n++;
            if (n % 2 == int'(cpha))
                rx[pos((n - 1) / 2)] = mosi;
            else if (n / 2 < int'(len))
                miso = tx[pos(n / 2)];
            if (n == 2 * int'(len))
                miso = ~miso;
        end
    end
endmodule
`default_nettype wire

//--- rtl/spisp_clk_if.sv
`default_nettype none
interface spisp_clk_if;
    logic        run;
    logic [15:0] div;
    logic        src_tick;
    logic        edge_p;
    modport gen (input run, input div, input src_tick, output edge_p);
    modport core (output run, output div, output src_tick, input edge_p);
endinterface
`default_nettype wire

//--- rtl/spisp_clkgen.sv
`default_nettype none
`include "spisp_consts.svh"
module spisp_clkgen (
    input wire logic clk,
    input wire logic rst_n,
    spisp_clk_if.gen cg
);
    import spisp_pkg::*;

    spisp_gen_t g_reg;
    spisp_gen_t g_next;

    // source ticks per half period; odd dividers of 3 and up split floor/ceil, below 2 one tick each half
    function automatic logic [15:0] half_len(input logic [15:0] div, input logic second);
        logic [15:0] h;
        h = second ? div - (div >> 1) : div >> 1;
        half_len = (div < `SPISP_DIV_MIN) ? 16'h0001 : h;
    endfunction

    always_comb
    begin
        g_next = g_reg;
        g_next.edge_p = 1'b0;
        if (!cg.run)
        begin
            g_next.cnt = 16'h0000;
            g_next.phase = 1'b0;
        end
        else if (cg.src_tick)
        begin
            if (g_reg.cnt + 16'h0001 >= half_len(cg.div, g_reg.phase))
            begin
                g_next.cnt = 16'h0000;
                g_next.phase = !g_reg.phase;
                g_next.edge_p = 1'b1;
            end
            else
                g_next.cnt = g_reg.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            g_reg <= '0;
        else
            g_reg <= g_next;
    end

    assign cg.edge_p = g_reg.edge_p;
endmodule
`default_nettype wire

//--- rtl/spisp_consts.svh
`ifndef SPISP_CONSTS_SVH
`define SPISP_CONSTS_SVH
`define SPISP_A_CTL0 6'h00
`define SPISP_A_CTL1 6'h04
`define SPISP_A_BR0 6'h08
`define SPISP_A_BR1 6'h0c
`define SPISP_A_MCTL 6'h10
`define SPISP_A_STAT 6'h14
`define SPISP_A_RXB 6'h18
`define SPISP_A_TXB 6'h1c
`define SPISP_A_IE 6'h20
`define SPISP_A_IFG 6'h24
`define SPISP_CPH 7
`define SPISP_CPL 6
`define SPISP_MSB 5
`define SPISP_B7 4
`define SPISP_MST 3
`define SPISP_SYN 0
`define SPISP_SWRST 0
`define SPISP_SSEL_HI 7
`define SPISP_FE 6
`define SPISP_OE 5
`define SPISP_BUSY 0
`define SPISP_RXB 0
`define SPISP_TXB 1
`define SPISP_RST_CTL1 8'h01
`define SPISP_M3PIN 2'b00
`define SPISP_MHIGH 2'b01
`define SPISP_LAST8 4'hf
`define SPISP_LAST7 4'hd
`define SPISP_DIV_MIN 16'h0002
`define SPISP_SYNC_N 2
`endif

//--- rtl/spisp_pkg.sv
`default_nettype none
package spisp_pkg;
    typedef enum logic [1:0] {
        SPISP_IDLE = 2'b00,
        SPISP_RUN  = 2'b01
    } spisp_state_t;
    typedef struct packed {
        logic [7:0]   ctl0;
        logic [7:0]   ctl1;
        logic [7:0]   divider_low_byte;
        logic [7:0]   divider_high_byte;
        logic [7:0]   modulation_control;
        logic         rx_int_enable;
        logic         tx_int_enable;
        logic         rx_flag;
        logic         tx_flag;
        logic         overrun_error;
        logic         mode_fault_error;
        logic [7:0]   receive_buffer;
        logic [7:0]   transmit_buffer;
        logic         tx_full;
        spisp_state_t st;
        logic [7:0]   tx_sr;
        logic [7:0]   rx_sr;
        logic [3:0]   ecnt;
        logic         sclk_prev;
        logic         sclk_o;
        logic         sclk_oe;
        logic         simo_o;
        logic         simo_oe;
        logic         somi_o;
        logic         somi_oe;
        logic         ack;
        logic [7:0]   dat;
    } spisp_core_t;
    typedef struct packed {
        logic [15:0] cnt;
        logic        phase;
        logic        edge_p;
    } spisp_gen_t;
endpackage
`default_nettype wire

//--- rtl/spisp_sync.sv
`default_nettype none
`include "spisp_consts.svh"
module spisp_sync #(
    parameter int W = 4,
    parameter int N = `SPISP_SYNC_N
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [N-1:0][W-1:0] s_reg;
    logic [N-1:0][W-1:0] s_next;

    if (N < 2)
    begin : g_bad
        $error("spisp_sync needs at least two stages");
    end

    always_comb
    begin
        s_next = {s_reg[N-2:0], d};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign q = s_reg[N-1];
endmodule
`default_nettype wire

//--- rtl/spisp_top.sv
`default_nettype none
`include "spisp_consts.svh"
module spisp_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        aux_clk_tick,
    input  wire logic        serial_clock_pin_i,
    output logic             serial_clock_pin_o,
    output logic             serial_clock_pin_oe,
    input  wire logic        slave_in_master_out_pin_i,
    output logic             slave_in_master_out_pin_o,
    output logic             slave_in_master_out_pin_oe,
    input  wire logic        slave_out_master_in_pin_i,
    output logic             slave_out_master_in_pin_o,
    output logic             slave_out_master_in_pin_oe,
    input  wire logic        slave_enable_pin_i
);
    import spisp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic        rst_meta_n;
    logic        rst_sync_n;
    logic [3:0]  pin_s;
    logic        sclk_s;
    logic        simo_s;
    logic        somi_s;
    logic        ste_s;
    spisp_core_t c_reg;
    spisp_core_t n;
    logic        cph;
    logic        cpl;
    logic        msbf;
    logic        b7;
    logic        mst;
    logic        swrst;
    logic        spi_on;
    logic        m_act;
    logic        s_act;
    logic [1:0]  pmode;
    logic [5:0]  adr;
    logic [7:0]  wd;
    logic        req;
    logic        wr;
    logic        rd;
    logic        wr_tx;
    logic        rd_rx;
    logic        do_load;
    logic        do_edge;
    logic        fin;
    logic        set_oe;
    logic        set_fe;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic ste_ok(input logic [1:0] m, input logic ste,
                                    input logic as_mst);
        logic slv;
        slv = (m == `SPISP_MHIGH) ? ste : !ste;
        ste_ok = (m == `SPISP_M3PIN) | (as_mst ? !slv : slv);
    endfunction

    function automatic logic out_bit(input logic [7:0] t, input logic m, input logic s7);
        out_bit = m ? (s7 ? t[6] : t[7]) : t[0];
    endfunction

    function automatic logic [7:0] tx_shift(input logic [7:0] t, input logic m);
        tx_shift = m ? {t[6:0], 1'b0} : {1'b0, t[7:1]};
    endfunction

    function automatic logic [7:0] rx_in(input logic [7:0] r, input logic b, input logic m);
        rx_in = m ? {r[6:0], b} : {b, r[7:1]};
    endfunction

    function automatic logic [7:0] rx_align(input logic [7:0] r, input logic m,
                                            input logic s7);
        if (!s7)
            rx_align = r;
        else if (m)
            rx_align = {1'b0, r[6:0]};
        else
            rx_align = {1'b0, r[7:1]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    spisp_sync #(
        .W (4),
        .N (`SPISP_SYNC_N)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .d     ({slave_enable_pin_i, slave_out_master_in_pin_i,
                 slave_in_master_out_pin_i, serial_clock_pin_i}),
        .q     (pin_s)
    );

    assign sclk_s = pin_s[0];
    assign simo_s = pin_s[1];
    assign somi_s = pin_s[2];
    assign ste_s = pin_s[3];

    ////////////////////////////////////////////////////////////////////////////
    // bit clock generator
    spisp_clk_if cg ();

    assign cg.run = (c_reg.st == SPISP_RUN) && mst;
    assign cg.div = {c_reg.divider_high_byte, c_reg.divider_low_byte};
    assign cg.src_tick = c_reg.ctl1[`SPISP_SSEL_HI] ? 1'b1 : aux_clk_tick;

    spisp_clkgen u_gen (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .cg    (cg.gen)
    );

    ////////////////////////////////////////////////////////////////////////////
    // configuration decode
    assign cph = c_reg.ctl0[`SPISP_CPH];
    assign cpl = c_reg.ctl0[`SPISP_CPL];
    assign msbf = c_reg.ctl0[`SPISP_MSB];
    assign b7 = c_reg.ctl0[`SPISP_B7];
    assign mst = c_reg.ctl0[`SPISP_MST];
    assign pmode = c_reg.ctl0[`SPISP_MST-1:`SPISP_SYN+1];
    assign swrst = c_reg.ctl1[`SPISP_SWRST];
    assign spi_on = c_reg.ctl0[`SPISP_SYN] && !swrst;
    assign m_act = ste_ok(pmode, ste_s, 1'b1);
    assign s_act = ste_ok(pmode, ste_s, 1'b0);

    ////////////////////////////////////////////////////////////////////////////
    // wishbone classic slave, ack one cycle after the request
    assign adr = {wb_adr_i[5:2], 2'b00};
    assign wd = wb_dat_i[7:0];
    assign req = wb_cyc_i && wb_stb_i && !c_reg.ack;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;
    assign wr_tx = wr && (adr == `SPISP_A_TXB);
    assign rd_rx = rd && (adr == `SPISP_A_RXB);

    always_comb
    begin
        n = c_reg;
        do_load = 1'b0;
        do_edge = 1'b0;
        fin = 1'b0;
        set_oe = 1'b0;
        set_fe = 1'b0;
        n.ack = req;
        n.dat = 8'h00;
        n.sclk_prev = sclk_s;
        if (rd)
        begin
            if (adr == `SPISP_A_CTL0)
                n.dat = c_reg.ctl0;
            else if (adr == `SPISP_A_CTL1)
                n.dat = c_reg.ctl1;
            else if (adr == `SPISP_A_BR0)
                n.dat = c_reg.divider_low_byte;
            else if (adr == `SPISP_A_BR1)
                n.dat = c_reg.divider_high_byte;
            else if (adr == `SPISP_A_MCTL)
                n.dat = c_reg.modulation_control;
            else if (adr == `SPISP_A_STAT)
            begin
                n.dat[`SPISP_FE] = c_reg.mode_fault_error;
                n.dat[`SPISP_OE] = c_reg.overrun_error;
                n.dat[`SPISP_BUSY] = (c_reg.st == SPISP_RUN);
            end
            else if (adr == `SPISP_A_RXB)
            begin
                n.dat = c_reg.receive_buffer;
                n.rx_flag = 1'b0;
            end
            else if (adr == `SPISP_A_TXB)
                n.dat = c_reg.transmit_buffer;
            else if (adr == `SPISP_A_IE)
            begin
                n.dat[`SPISP_RXB] = c_reg.rx_int_enable;
                n.dat[`SPISP_TXB] = c_reg.tx_int_enable;
            end
            else if (adr == `SPISP_A_IFG)
            begin
                n.dat[`SPISP_RXB] = c_reg.rx_flag;
                n.dat[`SPISP_TXB] = c_reg.tx_flag;
            end
        end
        if (wr)
        begin
            if (adr == `SPISP_A_CTL0)
                n.ctl0 = wd;
            else if (adr == `SPISP_A_CTL1)
                n.ctl1 = wd;
            else if (adr == `SPISP_A_BR0)
                n.divider_low_byte = wd;
            else if (adr == `SPISP_A_BR1)
                n.divider_high_byte = wd;
            else if (adr == `SPISP_A_MCTL)
                n.modulation_control = wd;
            else if (adr == `SPISP_A_STAT)
            begin
                n.mode_fault_error = wd[`SPISP_FE];
                n.overrun_error = wd[`SPISP_OE];
            end
            else if (adr == `SPISP_A_TXB)
            begin
                n.transmit_buffer = wd;
                n.tx_full = 1'b1;
                n.tx_flag = 1'b0;
            end
            else if (adr == `SPISP_A_IE)
            begin
                n.rx_int_enable = wd[`SPISP_RXB];
                n.tx_int_enable = wd[`SPISP_TXB];
            end
        end

        // shift engine
        if (!spi_on)
        begin
            n.st = SPISP_IDLE;
            n.ecnt = 4'h0;
            n.sclk_o = cpl;
            n.sclk_oe = 1'b0;
            n.simo_oe = 1'b0;
            n.somi_oe = 1'b0;
        end
        else if (mst)
        begin
            n.sclk_oe = m_act;
            n.simo_oe = m_act;
            n.somi_oe = 1'b0;
            if (!m_act)
            begin
                n.st = SPISP_IDLE;
                n.ecnt = 4'h0;
                n.sclk_o = cpl;
                set_fe = 1'b1;
            end
            else if (c_reg.st == SPISP_IDLE)
            begin
                n.sclk_o = cpl;
                if (c_reg.tx_full)
                begin
                    do_load = 1'b1;
                    n.st = SPISP_RUN;
                    n.ecnt = 4'h0;
                end
            end
            else if (cg.edge_p)
            begin
                n.sclk_o = !c_reg.sclk_o;
                do_edge = 1'b1;
            end
        end
        else
        begin
            n.sclk_oe = 1'b0;
            n.simo_oe = 1'b0;
            n.somi_oe = s_act;
            if ((c_reg.st == SPISP_IDLE) && c_reg.tx_full)
                do_load = 1'b1;
            if (s_act && (sclk_s != c_reg.sclk_prev))
            begin
                do_edge = 1'b1;
                n.st = SPISP_RUN;
            end
        end

        if (do_load)
        begin
            n.tx_sr = c_reg.transmit_buffer;
            n.tx_full = wr_tx;
            n.tx_flag = !wr_tx;
        end

        if (do_edge)
        begin
            if (c_reg.ecnt[0] ^ cph)
                n.rx_sr = rx_in(n.rx_sr, mst ? somi_s : simo_s, msbf);
            else if (c_reg.ecnt != 4'h0)
                n.tx_sr = tx_shift(n.tx_sr, msbf);
            if (c_reg.ecnt == (b7 ? `SPISP_LAST7 : `SPISP_LAST8))
            begin
                fin = 1'b1;
                n.receive_buffer = rx_align(n.rx_sr, msbf, b7);
                set_oe = n.rx_flag;
                n.rx_flag = 1'b1;
                n.st = SPISP_IDLE;
                n.ecnt = 4'h0;
            end
            else
                n.ecnt = c_reg.ecnt + 4'h1;
        end

        n.simo_o = out_bit(n.tx_sr, msbf, b7);
        n.somi_o = out_bit(n.tx_sr, msbf, b7);
        if (set_oe)
            n.overrun_error = 1'b1;
        if (set_fe)
            n.mode_fault_error = 1'b1;

        if (swrst)
        begin
            n.rx_int_enable = 1'b0;
            n.tx_int_enable = 1'b0;
            n.rx_flag = 1'b0;
            n.overrun_error = 1'b0;
            n.mode_fault_error = 1'b0;
            n.tx_flag = 1'b1;
            n.tx_full = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            c_reg <= '0;
            c_reg.ctl1 <= `SPISP_RST_CTL1;
            c_reg.tx_flag <= 1'b1;
        end
        else
            c_reg <= n;
    end

    ////////////////////////////////////////////////////////////////////////////
    assign wb_dat_o = {24'h000000, c_reg.dat};
    assign wb_ack_o = c_reg.ack;
    assign serial_clock_pin_o = c_reg.sclk_o;
    assign serial_clock_pin_oe = c_reg.sclk_oe;
    assign slave_in_master_out_pin_o = c_reg.simo_o;
    assign slave_in_master_out_pin_oe = c_reg.simo_oe;
    assign slave_out_master_in_pin_o = c_reg.somi_o;
    assign slave_out_master_in_pin_oe = c_reg.somi_oe;

    ////////////////////////////////////////////////////////////////////////////
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!rst_sync_n);

    property p_swrst_init;
        swrst |=> c_reg.tx_flag && !c_reg.rx_flag && !c_reg.overrun_error
                  && !c_reg.mode_fault_error && !c_reg.rx_int_enable
                  && !c_reg.tx_int_enable && (c_reg.st == SPISP_IDLE);
    endproperty
    a_swrst_init: assert property (p_swrst_init)
        else $error("soft reset left a flag or enable wrong");

    property p_txw_clear;
        wr_tx && !swrst |=> !c_reg.tx_flag && c_reg.tx_full;
    endproperty
    a_txw_clear: assert property (p_txw_clear)
        else $error("transmit write did not clear tx_flag");

    property p_rxr_clear;
        rd_rx && !fin && !swrst |=> !c_reg.rx_flag;
    endproperty
    a_rxr_clear: assert property (p_rxr_clear)
        else $error("receive read did not clear rx_flag");

    property p_overrun;
        fin && c_reg.rx_flag && !rd_rx && !swrst |=> c_reg.overrun_error && c_reg.rx_flag;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("unread character overwritten without overrun");

    property p_mfault;
        spi_on && mst && !m_act |=> c_reg.mode_fault_error && !c_reg.sclk_oe
                                    && !c_reg.simo_oe && (c_reg.st == SPISP_IDLE);
    endproperty
    a_mfault: assert property (p_mfault)
        else $error("inactive master kept driving or missed mode fault");

    sequence s_tx_write;
        wr_tx && spi_on && mst && m_act && (c_reg.st == SPISP_IDLE) && !c_reg.tx_full;
    endsequence
    sequence s_shift_start;
        (c_reg.st == SPISP_RUN) && c_reg.tx_flag && !c_reg.tx_full;
    endsequence
    property p_mstart;
        s_tx_write ##1 (spi_on && m_act && !wr_tx) |=> s_shift_start;
    endproperty
    a_mstart: assert property (p_mstart)
        else $error("master did not start after transmit write");

    property p_load_flag;
        do_load && !wr_tx && !swrst |=> c_reg.tx_flag && !c_reg.tx_full;
    endproperty
    a_load_flag: assert property (p_load_flag)
        else $error("tx_flag not set on move to shift register");

    property p_slv_halt;
        spi_on && !mst && !s_act |=> !c_reg.somi_oe && (c_reg.ecnt == $past(c_reg.ecnt));
    endproperty
    a_slv_halt: assert property (p_slv_halt)
        else $error("inactive slave kept shifting or driving");

    property p_gen_idle;
        (c_reg.st == SPISP_IDLE) |=> !cg.edge_p;
    endproperty
    a_gen_idle: assert property (p_gen_idle)
        else $error("bit clock edge while idle");

    property p_clk_idle;
        spi_on && mst && m_act && (c_reg.st == SPISP_IDLE) |=> c_reg.sclk_o == $past(cpl);
    endproperty
    a_clk_idle: assert property (p_clk_idle)
        else $error("idle clock level differs from polarity");

    property p_seven;
        fin && b7 |=> !c_reg.receive_buffer[7];
    endproperty
    a_seven: assert property (p_seven)
        else $error("seven-bit character has top bit set");
endmodule
`default_nettype wire
